//--- upsc_pkg.sv
// Package with shared constants and types for the USB port power state controller.
`default_nettype none
package upsc_pkg;
  // ==========================================================================
  // Power states, one-hot.
  typedef enum logic [5:0] {
    ST_OFF    = 6'b00_0001,
    ST_SLEEP  = 6'b00_0010,
    ST_DETECT = 6'b00_0100,
    ST_BYPOFF = 6'b00_1000,
    ST_DISCH  = 6'b01_0000,
    ST_ACTIVE = 6'b10_0000
  } upsc_state_t;

  // ==========================================================================
  // Mode codes of the three mode controls {emulation, a, b}.
  localparam logic [2:0] MODE_NONE      = 3'h0;
  localparam logic [2:0] MODE_PASSTHRU  = 3'h1;
  localparam logic [2:0] MODE_DCE_CYCLE = 3'h7;

  // ==========================================================================
  // Timing, in nanoseconds, and derived cycle counts at 125 MHz.
  localparam int CLK_PERIOD_NS       = 8;
  localparam int DISCHARGE_TIME_NS   = 200000;
  localparam int ATTACH_QUAL_NS      = 100000;
  localparam int REMOVAL_QUAL_NS     = 100000;
  localparam int WAKE_HOLD_NS        = 1000000;
  localparam int PROFILE_DWELL_NS    = 2000000;
  localparam int DISCHARGE_CYC = (DISCHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ATTACH_QUAL_CYC = (ATTACH_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REMOVAL_QUAL_CYC = (REMOVAL_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_HOLD_CYC = WAKE_HOLD_NS / CLK_PERIOD_NS;
  localparam int PROFILE_DWELL_CYC = PROFILE_DWELL_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Reset values and profile count.
  localparam logic [3:0] ILIM_POWERUP   = 4'hF;
  localparam logic [3:0] PROFILE_COUNT  = 4'h9;
  localparam logic [3:0] PROFILE_FIRST  = 4'h0;

  // ==========================================================================
  // Control bits written over the management bus, OR'd with the pins.
  typedef struct packed {
    logic       powerEnable;
    logic       modeA;
    logic       modeB;
    logic       emulation;
  } upsc_ctrl_t;

  // Switch drive bundle.
  typedef struct packed {
    logic portSwitch;
    logic bypassSwitch;
    logic dischargeSwitch;
    logic hsSwitch;
  } upsc_sw_t;
endpackage : upsc_pkg
`default_nettype wire

//--- upsc_power_state.sv
// Power-state controller for a USB port power switch.
// Function
// R1: Low core supply forces Off: state lost, bus ignored, all switches open.
// R2: Sleep opens high-speed, bypass, port switches; VBUS grounded; detection off.
// R3: Entering Sleep releases the error alert and the attach flag.
// R4: In Sleep only single-byte bus reads or writes are used and accepted.
// R5: First byte read in Sleep wakes the device and returns zeros.
// R6: After wake, bytes are served normally; Sleep resumes after traffic ends.
// R7: Sleep when disabled, detect 0, not pass-through; or enabled with mode zero.
// R8: Detect 1 with enable off or source low holds Detect; host moves on.
// R9: Detect 1, enabled, source good, mode set: wait, go Active on attach.
// R10: Detect 0, enabled, source good, mode set: Active, port closed, detection off.
// R11: Charger emulation cycle with nothing attached keeps cycling profiles.
// R12: Host changes mode controls before enable when leaving pass-through for Sleep.
// R13: Detect opens port and high-speed switches, feeds VBUS through bypass.
// R14: Detect keeps configuration, bus alive, does not monitor bus current.
// R15: Host completes host-controlled Detect by supplying enable or source.
// R16: Detect to Active: detection change, bypass off, discharge pulse, port on.
// R17: Detect 1, enabled, no source: attach flag toggles on bypass overload.
// R18: Current limit set at power-up; host may only lower it later.
// R19: Sleep keeps digital state, follows mode changes, wakes for bus traffic.
// R20: Each control is pin OR configuration bit; the attach detect control is pin only here.
// R21: Attach event when current exceeds attach level for the qualification time.
// R22: Removal event when load below removal level for the qualification time.
// R23: On core supply return all controls reset to defaults first.
`default_nettype none
module upsc_power_state #(
  parameter int DischargeCyc    = upsc_pkg::DISCHARGE_CYC,     // Discharge pulse length.
  parameter int AttachQualCyc   = upsc_pkg::ATTACH_QUAL_CYC,   // Attach qualification.
  parameter int RemovalQualCyc  = upsc_pkg::REMOVAL_QUAL_CYC,  // Removal qualification.
  parameter int WakeHoldCyc     = upsc_pkg::WAKE_HOLD_CYC,     // Bus idle before re-sleep.
  parameter int ProfileDwellCyc = upsc_pkg::PROFILE_DWELL_CYC  // Time per emulation profile.
) (
  input  wire logic                ref_clk,            // System clock, 125 MHz.
  input  wire logic                srst,               // Synchronous reset, active high.
  input  wire logic                coreSupplyGood,     // Core supply above threshold, pin.
  input  wire logic                sourceAboveLockout, // Source above lockout, pin.
  input  wire upsc_pkg::upsc_ctrl_t ctrlPins,          // Mode and enable pins.
  input  wire logic                attachDetectEnable, // Attach detect control pin.
  input  wire logic                attachCurrentHigh,  // Load above attach level, pin.
  input  wire logic                removalCurrentLow,  // Load below removal level, pin.
  input  wire logic                bypassOverload,     // Bypass switch over capacity, pin.
  input  wire logic                errorEvent,         // Error condition from fault logic.
  input  wire logic                cfgWrite,           // Single-byte config write strobe.
  input  wire upsc_pkg::upsc_ctrl_t cfgData,           // Config bits written.
  input  wire logic                ilimWrite,          // Current limit write strobe.
  input  wire logic [3:0]          ilimData,           // Requested current limit.
  input  wire logic                rdStrobe,           // Single-byte read request.
  input  wire logic [7:0]          rdDataIn,           // Register data to return.
  output logic [7:0]               rdData,             // Read data returned.
  output logic                     rdValid,            // Read data valid pulse.
  output upsc_pkg::upsc_sw_t       switches,           // Switch drives.
  output logic                     alertOe,            // Alert pin pulled low when high.
  output logic                     attachFlagOe,       // attach_flag_n pulled low when high.
  output logic [3:0]               currentLimit,       // Active current limit.
  output logic [3:0]               profileSel,         // Emulation profile applied.
  output upsc_pkg::upsc_state_t    powerState          // Current power state.
);

  // ==========================================================================
  // Input synchronisers; first stages are read only by the second.
  logic [8:0] syncA_q;
  logic [8:0] syncB_q;
  always_ff @(posedge ref_clk) begin
    syncA_q <= {coreSupplyGood, sourceAboveLockout, ctrlPins, attachDetectEnable,
                attachCurrentHigh, removalCurrentLow};
    syncB_q <= syncA_q;
  end
  wire logic vddOk   = syncB_q[8];
  wire logic srcOk   = syncB_q[7];
  wire upsc_pkg::upsc_ctrl_t pinCtl = syncB_q[6:3];
  wire logic detEn   = syncB_q[2];
  wire logic curHigh = syncB_q[1];
  wire logic curLow  = syncB_q[0];
  logic ovl_a_q;
  logic ovl_b_q;
  always_ff @(posedge ref_clk) begin
    ovl_a_q <= bypassOverload;
    ovl_b_q <= ovl_a_q;
  end

  // Internal reset: external reset or loss of core supply resets all state past the input synchronisers.
  wire logic clr = srst || !vddOk; // [R1] [R23]

  // ==========================================================================
  // Configuration bits, OR'd with the pins.
  upsc_pkg::upsc_ctrl_t cfg_q;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      cfg_q <= '0; // [R23]
    end else if (cfgWrite) begin
      cfg_q <= cfgData;
    end
  end
  wire upsc_pkg::upsc_ctrl_t ctl = pinCtl | cfg_q; // [R20]
  wire logic [2:0] mode = {ctl.emulation, ctl.modeA, ctl.modeB};
  wire logic modeSet = (mode != upsc_pkg::MODE_NONE);

  // Current limit: power-up value, later writes may only lower it.
  logic [3:0] ilim_q;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ilim_q <= upsc_pkg::ILIM_POWERUP; // [R18]
    end else if (ilimWrite && ilimData < ilim_q) begin
      ilim_q <= ilimData; // [R18]
    end
  end
  assign currentLimit = ilim_q;

  // ==========================================================================
  // Attach and removal qualification counters.
  logic [31:0] attCnt_q;
  logic [31:0] remCnt_q;
  logic        attachEvt;
  logic        removalEvt;
  logic        attachDetOn;
  logic        removalDetOn;
  always_ff @(posedge ref_clk) begin
    if (clr || !attachDetOn || !curHigh) begin
      attCnt_q <= '0;
    end else if (attCnt_q <= 32'(AttachQualCyc)) begin
      attCnt_q <= attCnt_q + 32'h0000_0001;
    end
  end
  assign attachEvt = (attCnt_q > 32'(AttachQualCyc)); // [R21]
  always_ff @(posedge ref_clk) begin
    if (clr || !removalDetOn || !curLow) begin
      remCnt_q <= '0;
    end else if (remCnt_q <= 32'(RemovalQualCyc)) begin
      remCnt_q <= remCnt_q + 32'h0000_0001;
    end
  end
  assign removalEvt = (remCnt_q > 32'(RemovalQualCyc)); // [R22]

  // ==========================================================================
  // Power state machine.
  upsc_pkg::upsc_state_t state_q;
  upsc_pkg::upsc_state_t state_d;
  logic [31:0] disCnt_q;
  logic        attached_q;

  // Sleep selection by the control table.
  wire logic wantSleep = (!ctl.powerEnable && !detEn && mode != upsc_pkg::MODE_PASSTHRU)
                      || (ctl.powerEnable && !modeSet); // [R7]
  // Active without detection.
  wire logic wantActiveDirect = !detEn && ctl.powerEnable && srcOk && modeSet; // [R10]
  // Automatic transition is possible only with everything supplied.
  wire logic autoReady = detEn && ctl.powerEnable && srcOk && modeSet; // [R9]

  always_comb begin
    state_d = state_q;
    case (state_q)
      upsc_pkg::ST_OFF: begin
        state_d = upsc_pkg::ST_SLEEP;
      end
      upsc_pkg::ST_SLEEP, upsc_pkg::ST_DETECT, upsc_pkg::ST_ACTIVE: begin
        if (wantSleep) begin
          state_d = upsc_pkg::ST_SLEEP; // [R7]
        end else if (wantActiveDirect) begin
          state_d = (state_q == upsc_pkg::ST_ACTIVE) ? upsc_pkg::ST_ACTIVE
                                                      : upsc_pkg::ST_BYPOFF; // [R10]
        end else if (detEn && state_q == upsc_pkg::ST_ACTIVE && attached_q && autoReady) begin
          state_d = upsc_pkg::ST_ACTIVE;
        end else if (autoReady && attached_q) begin
          state_d = upsc_pkg::ST_BYPOFF; // [R9] [R15]
        end else begin
          state_d = upsc_pkg::ST_DETECT; // [R8]
        end
      end
      upsc_pkg::ST_BYPOFF: begin
        state_d = upsc_pkg::ST_DISCH; // [R16]
      end
      upsc_pkg::ST_DISCH: begin
        if (disCnt_q >= 32'(DischargeCyc) - 32'h0000_0001) begin
          state_d = upsc_pkg::ST_ACTIVE; // [R16]
        end
      end
      default: begin
        state_d = upsc_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      state_q <= upsc_pkg::ST_OFF; // [R1]
    end else begin
      state_q <= state_d;
    end
  end
  assign powerState = state_q;

  // Discharge pulse length counter.
  always_ff @(posedge ref_clk) begin
    if (clr || state_q != upsc_pkg::ST_DISCH) begin
      disCnt_q <= '0;
    end else begin
      disCnt_q <= disCnt_q + 32'h0000_0001;
    end
  end

  // Attachment memory: set by attach event, cleared by removal, by Sleep or by leaving detect mode.
  // Set wins over the removal clear so a simultaneous attach is kept.
  always_ff @(posedge ref_clk) begin
    if (clr || !detEn || state_q == upsc_pkg::ST_SLEEP) begin
      attached_q <= 1'b0;
    end else if (attachEvt) begin
      attached_q <= 1'b1;
    end else if (removalEvt) begin
      attached_q <= 1'b0; // [R22]
    end
  end

  // Detection enables: attach only in Detect, removal while Active or Discharge with detect on.
  assign attachDetOn  = (state_q == upsc_pkg::ST_DETECT) && !attached_q; // [R16]
  assign removalDetOn = detEn && (state_q == upsc_pkg::ST_ACTIVE ||
                                  state_q == upsc_pkg::ST_DISCH); // [R16] [R10] [R2]

  // ==========================================================================
  // Switch drives, registered.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      switches <= '0; // [R1]
    end else begin
      switches.portSwitch      <= (state_d == upsc_pkg::ST_ACTIVE); // [R16] [R10]
      switches.bypassSwitch    <= (state_d == upsc_pkg::ST_DETECT); // [R13] [R2]
      switches.dischargeSwitch <= (state_d == upsc_pkg::ST_DISCH) ||
                                  (state_d == upsc_pkg::ST_SLEEP); // [R2] [R16]
      // High-speed switch closed only in Active data modes, never in Detect.
      switches.hsSwitch        <= (state_d == upsc_pkg::ST_ACTIVE) &&
                                  (mode != upsc_pkg::MODE_DCE_CYCLE); // [R13]
    end
  end

  // ==========================================================================
  // Flags: alert latches on error until Sleep; attach flag shows attachment.
  // Bypass overload with no source makes the attach flag toggle as bypass trips.
  always_ff @(posedge ref_clk) begin
    if (clr || state_d == upsc_pkg::ST_SLEEP) begin
      alertOe      <= 1'b0; // [R3]
      attachFlagOe <= 1'b0; // [R3]
    end else begin
      if (errorEvent) begin
        alertOe <= 1'b1;
      end
      if (state_q == upsc_pkg::ST_DETECT && ctl.powerEnable && !srcOk && ovl_b_q) begin
        attachFlagOe <= !attachFlagOe; // [R17]
      end else begin
        attachFlagOe <= attached_q;
      end
    end
  end

  // ==========================================================================
  // Emulation profile cycling while nothing is attached in cycle mode.
  logic [31:0] dwell_q;
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      dwell_q    <= '0;
      profileSel <= upsc_pkg::PROFILE_FIRST;
    end else if (state_q == upsc_pkg::ST_ACTIVE && mode == upsc_pkg::MODE_DCE_CYCLE
                 && !detEn && !curHigh) begin
      if (dwell_q >= 32'(ProfileDwellCyc) - 32'h0000_0001) begin
        dwell_q    <= '0;
        profileSel <= (profileSel == upsc_pkg::PROFILE_COUNT - 4'h1) ? upsc_pkg::PROFILE_FIRST
                                                                      : profileSel + 4'h1; // [R11]
      end else begin
        dwell_q <= dwell_q + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Sleep wake on dummy read; re-sleep after the bus stays quiet.
  logic        awake_q;
  logic [31:0] idle_q;
  always_ff @(posedge ref_clk) begin
    if (clr || state_q != upsc_pkg::ST_SLEEP) begin
      awake_q <= 1'b0;
      idle_q  <= '0;
    end else if (rdStrobe || cfgWrite) begin
      idle_q <= '0;
      if (rdStrobe) begin
        awake_q <= 1'b1; // [R5] [R19]
      end
    end else if (awake_q) begin
      if (idle_q >= 32'(WakeHoldCyc) - 32'h0000_0001) begin
        awake_q <= 1'b0; // [R6]
        idle_q  <= '0;
      end else begin
        idle_q <= idle_q + 32'h0000_0001;
      end
    end
  end

  // Read data: zeros for the dummy byte, normal data otherwise; Off ignores the bus.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      rdData  <= 8'h00; // [R1]
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdStrobe && state_q != upsc_pkg::ST_OFF;
      if (state_q == upsc_pkg::ST_SLEEP && !awake_q) begin
        rdData <= 8'h00; // [R5]
      end else begin
        rdData <= rdDataIn; // [R6] [R14] [R4]
      end
    end
  end

endmodule : upsc_power_state
`default_nettype wire

//--- upsc_power_state_sva.sv
// Checker of the port power state controller, bound to its top module.
`default_nettype none
module upsc_power_state_sva #(
  parameter int DischargeCyc = 4  // Discharge pulse length in cycles.
) (
  input wire logic                  ref_clk,        // Clock.
  input wire logic                  srst,           // Synchronous reset.
  input wire logic                  coreSupplyGood, // Core supply good.
  input wire logic                  rdStrobe,       // Read request.
  input wire logic                  rdValid,        // Read answer.
  input wire upsc_pkg::upsc_sw_t    switches,       // Switch drives.
  input wire logic                  alertOe,        // Alert drive.
  input wire logic                  attachFlagOe,   // Attach flag drive.
  input wire logic [3:0]            currentLimit,   // Current limit.
  input wire upsc_pkg::upsc_state_t powerState      // Power state.
);
  // ==========================================================================
  // Cycles spent in discharge; a counter keeps long pulses cheap to check.
  int dischCnt_q;
  always_ff @(posedge ref_clk) begin
    if (srst || powerState != upsc_pkg::ST_DISCH) dischCnt_q <= 0;
    else dischCnt_q <= dischCnt_q + 1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Assertions on switches, flags, reads and limit.
  off_all_open_a: assert property (powerState == upsc_pkg::ST_OFF |-> switches == 4'h0
    && !alertOe && !attachFlagOe) else $error("Off state drives an output");
  off_entry_a: assert property (!coreSupplyGood [*4] |-> powerState == upsc_pkg::ST_OFF)
    else $error("Low core supply did not force Off");
  sleep_switch_a: assert property (powerState == upsc_pkg::ST_SLEEP |-> switches == 4'h2)
    else $error("Sleep switch pattern wrong");
  sleep_flags_a: assert property (powerState == upsc_pkg::ST_SLEEP |-> !alertOe && !attachFlagOe)
    else $error("Flag still driven in Sleep");
  detect_switch_a: assert property (powerState == upsc_pkg::ST_DETECT |-> !switches.portSwitch
    && switches.bypassSwitch && !switches.hsSwitch) else $error("Detect switch pattern wrong");
  bypass_first_a: assert property (powerState == upsc_pkg::ST_BYPOFF |-> !switches.bypassSwitch
    && !switches.portSwitch ##1 powerState == upsc_pkg::ST_DISCH) else $error("Bypass step wrong");
  // A core supply loss may cut the pulse short, so an exit into Off is not judged here.
  disch_length_a: assert property ($past(powerState) == upsc_pkg::ST_DISCH
    && powerState != upsc_pkg::ST_DISCH && powerState != upsc_pkg::ST_OFF
    |-> $past(dischCnt_q) == DischargeCyc - 1
    && powerState == upsc_pkg::ST_ACTIVE) else $error("Discharge pulse length wrong");
  active_port_a: assert property (powerState == upsc_pkg::ST_ACTIVE |-> switches.portSwitch
    && !switches.bypassSwitch && !switches.dischargeSwitch) else $error("Active port not closed");
  read_answer_a: assert property (rdStrobe && powerState != upsc_pkg::ST_OFF |=> rdValid)
    else $error("Read not answered");
  read_cause_a: assert property (rdValid |-> $past(rdStrobe))
    else $error("Read answer without request");
  limit_lower_a: assert property (powerState != upsc_pkg::ST_OFF
    && $past(powerState) != upsc_pkg::ST_OFF |-> currentLimit <= $past(currentLimit))
    else $error("Current limit rose");

  cover property (powerState == upsc_pkg::ST_DISCH);
  cover property (rdValid && powerState == upsc_pkg::ST_SLEEP);
  cover property (powerState == upsc_pkg::ST_ACTIVE && !switches.hsSwitch);
endmodule // upsc_power_state_sva

bind upsc_power_state upsc_power_state_sva #(.DischargeCyc(DischargeCyc)) chk (.ref_clk, .srst,
  .coreSupplyGood, .rdStrobe, .rdValid, .switches, .alertOe, .attachFlagOe, .currentLimit,
  .powerState);
`default_nettype wire

//--- upsc_dev_model.sv
// Behavioural model of the portable device attached to the port.
`default_nettype none
module upsc_dev_model (
  input  wire logic ref_clk,           // Clock.
  input  wire logic plugged,           // Device inserted.
  input  wire logic overdraw,          // Device draws beyond bypass capacity.
  output logic      attachCurrentHigh, // Load above attach level.
  output logic      removalCurrentLow, // Load below removal level.
  output logic      bypassOverload     // Bypass over capacity.
);
  // ==========================================================================
  // Current ramps a few cycles after insertion, as a real plug bounces first.
  logic [2:0] plugAge_q;
  always_ff @(posedge ref_clk) begin
    plugAge_q <= plugged ? ((plugAge_q == 3'h7) ? plugAge_q : plugAge_q + 3'h1) : 3'h0;
  end
  assign attachCurrentHigh = (plugAge_q > 3'h2);
  assign removalCurrentLow = !attachCurrentHigh;
  assign bypassOverload    = overdraw && plugged; // Only a drawing load overloads.
endmodule // upsc_dev_model
`default_nettype wire

//--- tb.sv
// Self-checking testbench of the port power state controller.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus, outputs and bookkeeping.
  typedef struct packed {
    upsc_pkg::upsc_state_t st;
    logic [3:0]            sw;
    logic [3:0]            il;
    logic                  al;
  } upsc_exp_t;
  logic ref_clk = 0, srst = 1, coreSupplyGood = 1, sourceAboveLockout = 0;
  logic attachDetectEnable = 0, errorEvent = 0, cfgWrite = 0, ilimWrite = 0, rdStrobe = 0;
  logic plugged = 0, overdraw = 0, attachCurrentHigh, removalCurrentLow, bypassOverload;
  upsc_pkg::upsc_ctrl_t ctrlPins = '0, cfgData = '0;
  logic [3:0] ilimData = 4'h0, currentLimit, profileSel, p0;
  logic [7:0] rdDataIn = 8'h00, rdData, r;
  logic rdValid, alertOe, attachFlagOe, f0;
  upsc_pkg::upsc_sw_t switches;
  upsc_pkg::upsc_state_t powerState;
  upsc_exp_t stQ[$], e;
  logic [7:0] rdQ[$];
  int miscompares = 0, samples_checked = 0, cyc = 0, seedV = 32'h15e3;
  event chkEv;

  always #4 ref_clk = ~ref_clk;

  upsc_power_state #(.DischargeCyc(4), .AttachQualCyc(4), .RemovalQualCyc(4),
    .WakeHoldCyc(20), .ProfileDwellCyc(8)) uut (.ref_clk, .srst, .coreSupplyGood,
    .sourceAboveLockout, .ctrlPins, .attachDetectEnable, .attachCurrentHigh, .removalCurrentLow,
    .bypassOverload, .errorEvent, .cfgWrite, .cfgData, .ilimWrite, .ilimData, .rdStrobe,
    .rdDataIn, .rdData, .rdValid, .switches, .alertOe, .attachFlagOe, .currentLimit,
    .profileSel, .powerState);
  upsc_dev_model dev (.ref_clk, .plugged, .overdraw, .attachCurrentHigh, .removalCurrentLow,
    .bypassOverload);

  // Closing report; the single exit of the run.
  task automatic stop_test();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Attach flag check; called away from the edge, where the flag has settled.
  task automatic flag_check(input logic expFlag);
    samples_checked++;
    if (attachFlagOe !== expFlag) begin
      miscompares++;
      $display("ERROR %0t attach flag differs", $time);
    end
  endtask
  // Outputs are noted away from the edge so that register updates have landed.
  task automatic expect_st(input upsc_pkg::upsc_state_t st, input logic [3:0] sw,
                           input logic [3:0] il, input logic al);
    @(negedge ref_clk);
    stQ.push_back('{st, sw, il, al});
    -> chkEv;
  endtask
  // Pins pass a two-stage synchroniser, so they are given time to settle.
  task automatic setp(input logic [3:0] c, input logic d, input logic s);
    @(posedge ref_clk);
    ctrlPins <= upsc_pkg::upsc_ctrl_t'(c);
    attachDetectEnable <= d;
    sourceAboveLockout <= s;
    tick(10);
  endtask
  task automatic rd(input logic zero);
    logic [7:0] v;
    v = 8'($random(seedV));
    @(posedge ref_clk);
    rdStrobe <= 1'b1;
    rdDataIn <= v;
    rdQ.push_back(zero ? 8'h00 : v);
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    tick(2);
  endtask
  task automatic ilim(input logic [3:0] v);
    @(posedge ref_clk);
    ilimWrite <= 1'b1;
    ilimData <= v;
    @(posedge ref_clk);
    ilimWrite <= 1'b0;
    tick(2);
  endtask

  // Result watchers take the oldest note and compare.
  always @(chkEv) begin
    e = stQ.pop_front();
    samples_checked++;
    if (powerState !== e.st || switches !== e.sw || currentLimit !== e.il || alertOe !== e.al) begin
      miscompares++;
      $display("ERROR %0t state or outputs differ", $time);
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
    if (rdValid === 1'b1) begin
      r = rdQ.pop_front();
      samples_checked++;
      if (rdData !== r) begin
        miscompares++;
        $display("ERROR %0t read data differs", $time);
      end
    end
  end

  // Main sequence.
  initial begin
    tick(2);
    expect_st(upsc_pkg::ST_OFF, 4'h0, 4'hF, 1'b0);
    @(posedge ref_clk);
    srst <= 1'b0;
    tick(10);
    expect_st(upsc_pkg::ST_SLEEP, 4'h2, 4'hF, 1'b0);
    rd(1'b1);
    rd(1'b0);
    tick(40);
    rd(1'b1);
    setp(4'h8, 1'b0, 1'b0);
    expect_st(upsc_pkg::ST_SLEEP, 4'h2, 4'hF, 1'b0);
    setp(4'hA, 1'b0, 1'b1);
    expect_st(upsc_pkg::ST_ACTIVE, 4'h9, 4'hF, 1'b0);
    ilim(4'h8);
    expect_st(upsc_pkg::ST_ACTIVE, 4'h9, 4'h8, 1'b0);
    ilim(4'hC);
    @(posedge ref_clk);
    errorEvent <= 1'b1;
    @(posedge ref_clk);
    errorEvent <= 1'b0;
    expect_st(upsc_pkg::ST_ACTIVE, 4'h9, 4'h8, 1'b1);
    setp(4'h8, 1'b0, 1'b1);
    expect_st(upsc_pkg::ST_SLEEP, 4'h2, 4'h8, 1'b0);
    setp(4'h0, 1'b1, 1'b1);
    expect_st(upsc_pkg::ST_DETECT, 4'h4, 4'h8, 1'b0);
    rd(1'b0);
    setp(4'hA, 1'b1, 1'b1);
    expect_st(upsc_pkg::ST_DETECT, 4'h4, 4'h8, 1'b0);
    @(posedge ref_clk);
    plugged <= 1'b1;
    tick(30);
    expect_st(upsc_pkg::ST_ACTIVE, 4'h9, 4'h8, 1'b0);
    flag_check(1'b1);
    @(posedge ref_clk);
    plugged <= 1'b0;
    tick(20);
    expect_st(upsc_pkg::ST_DETECT, 4'h4, 4'h8, 1'b0);
    flag_check(1'b0);
    // Host-controlled Detect: attach with no source, an overloaded bypass toggles the flag.
    setp(4'hA, 1'b1, 1'b0);
    @(posedge ref_clk);
    plugged <= 1'b1;
    overdraw <= 1'b1;
    tick(20);
    expect_st(upsc_pkg::ST_DETECT, 4'h4, 4'h8, 1'b0);
    f0 = attachFlagOe;
    @(negedge ref_clk);
    flag_check(!f0);
    @(posedge ref_clk);
    overdraw <= 1'b0;
    setp(4'hA, 1'b1, 1'b1);
    expect_st(upsc_pkg::ST_ACTIVE, 4'h9, 4'h8, 1'b0);
    @(posedge ref_clk);
    plugged <= 1'b0;
    setp(4'h0, 1'b0, 1'b0);
    @(posedge ref_clk);
    cfgWrite <= 1'b1;
    cfgData <= upsc_pkg::upsc_ctrl_t'(4'hA);
    @(posedge ref_clk);
    cfgWrite <= 1'b0;
    setp(4'h0, 1'b0, 1'b1);
    expect_st(upsc_pkg::ST_ACTIVE, 4'h9, 4'h8, 1'b0);
    @(posedge ref_clk);
    coreSupplyGood <= 1'b0;
    tick(10);
    expect_st(upsc_pkg::ST_OFF, 4'h0, 4'hF, 1'b0);
    @(posedge ref_clk);
    coreSupplyGood <= 1'b1;
    tick(10);
    expect_st(upsc_pkg::ST_SLEEP, 4'h2, 4'hF, 1'b0);
    setp(4'hF, 1'b0, 1'b1);
    expect_st(upsc_pkg::ST_ACTIVE, 4'h8, 4'hF, 1'b0);
    p0 = profileSel;
    tick(20);
    samples_checked++;
    if (profileSel === p0) begin
      miscompares++;
      $display("ERROR %0t emulation profile did not advance", $time);
    end
    tick(4);
    stop_test();
  end
endmodule // tb
`default_nettype wire
